/* File: packet_serial_rx_error_config_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module packet_serial_rx_error_config_tb;
	logic clock, reset_n, sfrWrite, sfrRead, rxDataReady, txActive, portLatchBit, slotTick, txClkExtIn;
	logic [7:0] sfrAddr, sfrWrData, sfrRdData_ff, rxData_ff, channelMode_ff, v;
	logic rxDataValid_ff, txBitTick_ff, lineDriverEnable_n_ff, rxErrorIrq_ff, preambleInvalid_ff;
	logic [6:0] preambleBits_ff;
	wire rxBitValid, rxBitValue, rxFrameStart, rxFrameEnd, rxLineIdle, rxCollision;
	int bad_count, check_count;
	logic [7:0] gotQ [$];
	psrx_channel u_dut (.clock, .reset_n, .sfrAddr, .sfrWrite, .sfrRead, .sfrWrData, .sfrRdData_ff,
		.rxBitValid, .rxBitValue, .rxFrameStart, .rxFrameEnd, .rxLineIdle, .rxCollision, .rxData_ff,
		.rxDataValid_ff, .rxDataReady, .txActive, .txClkExtIn, .portLatchBit, .slotTick, .txBitTick_ff,
		.lineDriverEnable_n_ff, .rxErrorIrq_ff, .preambleBits_ff, .preambleInvalid_ff, .channelMode_ff);
	psrx_remote_station u_st (.clock, .rxBitValid, .rxBitValue, .rxFrameStart, .rxFrameEnd, .rxLineIdle, .rxCollision);
	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	always @(posedge clock)
		if (rxDataValid_ff === 1'b1 && rxDataReady)
			gotQ.push_back(rxData_ff);
	task chk(input string n, input logic [7:0] s, input logic [7:0] e);
		check_count++;
		if (s !== e)
		begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task idle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		#1 sfrAddr = a;
		sfrWrData = d;
		sfrWrite = 1'b1;
		@(posedge clock);
		#1 sfrWrite = 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge clock);
		#1 sfrAddr = a;
		sfrRead = 1'b1;
		@(posedge clock);
		#1 sfrRead = 1'b0;
		v = sfrRdData_ff;
	endtask
	task st(input logic [7:0] m, input logic [7:0] e);
		rd(8'hE8);
		chk("status", v & m, e);
	endtask
	task frame(input logic [7:0] m, input logic [7:0] pre, input logic bad, input logic [7:0] post, input logic cut);
		wr(8'h84, m);
		wr(8'hE8, 8'h01);
		gotQ.delete();
		u_st.send(pre, bad, post, cut);
		idle(4);
	endtask
	task t_regs;
		logic [7:0] a [10] = '{8'h84, 8'h94, 8'h95, 8'hA5, 8'hB5, 8'hC4, 8'hC5, 8'hD5, 8'hE5, 8'h85};
		foreach (a[i])
		begin
			rd(a[i]);
			chk("reset value", v, 8'h00);
			wr(a[i], 8'h5A);
			rd(a[i]);
			chk("readback", v, i == 9 ? 8'h00 : 8'h5A);
			wr(a[i], 8'h00);
		end
	endtask
	task t_mode;
		for (int k = 0; k < 4; k++)
		begin
			wr(8'h84, {5'h00, k[1:0], 1'b1});
			idle(3);
			chk("preamble", {1'b0, preambleBits_ff}, k == 0 ? 8'h00 : k == 1 ? 8'h08 : k == 2 ? 8'h20 : 8'h40);
			chk("mode", channelMode_ff, {5'h00, k[1:0], 1'b1});
		end
		wr(8'h84, 8'h00);
		idle(3);
		chk("preamble invalid", {7'h00, preambleInvalid_ff}, 8'h01);
	endtask
	task t_good;
		wr(8'h95, 8'h5A);
		wr(8'hD5, 8'h0F);
		u_st.pay = '{8'h53, 8'hC3};
		frame(8'h01, 8'h00, 1'b0, 8'h07, 1'b0);
		st(8'hFF, 8'h03);
		chk("first byte", gotQ[0], 8'h53);
		chk("second byte", gotQ[1], 8'hC3);
		u_st.pay = '{8'h6A, 8'hC3};
		frame(8'h01, 8'h00, 1'b0, 8'h00, 1'b0);
		st(8'hFF, 8'h01);
		chk("dropped bytes", 8'(gotQ.size()), 8'h00);
	endtask
	task t_err;
		logic [7:0] r [6][4] = '{'{8'h01, 8'h00, 8'h01, 8'h10}, '{8'h01, 8'h03, 8'h00, 8'h20},
			'{8'h01, 8'h03, 8'h01, 8'h30}, '{8'h02, 8'h03, 8'h00, 8'h01}, '{8'h02, 8'h00, 8'h01, 8'h10},
			'{8'h02, 8'h03, 8'h01, 8'h20}};
		u_st.pay = '{8'h53, 8'hC3};
		foreach (r[i])
		begin
			frame(r[i][0], r[i][1], r[i][2][0], 8'h00, 1'b0);
			st(r[i][3] == 8'h01 ? 8'hF1 : 8'hF3, r[i][3]);
			chk("error irq", {7'h00, rxErrorIrq_ff}, {7'h00, r[i][3] != 8'h01});
		end
	endtask
	task t_abort;
		u_st.pay = '{8'h53, 8'hC3, 8'h11};
		frame(8'h01, 8'h00, 1'b0, 8'h00, 1'b1);
		st(8'hF3, 8'h40);
		wr(8'hE8, 8'hF0);
		st(8'hF3, 8'h40);
		wr(8'hE8, 8'h01);
		st(8'hF3, 8'h01);
	endtask
	task t_ovf;
		rxDataReady = 1'b0;
		u_st.pay = '{8'h53, 8'h01, 8'h02, 8'h03};
		frame(8'h01, 8'h00, 1'b0, 8'h00, 1'b0);
		st(8'hF3, 8'h80);
		rxDataReady = 1'b1;
		idle(4);
		chk("drained count", 8'(gotQ.size()), 8'h02);
		chk("head byte", gotQ[0], 8'h53);
	endtask
	task t_misc;
		int n;
		txActive = 1'b1;
		portLatchBit = 1'b1;
		idle(3);
		chk("driver enable", {7'h00, lineDriverEnable_n_ff}, 8'h00);
		portLatchBit = 1'b0;
		idle(3);
		chk("driver gated", {7'h00, lineDriverEnable_n_ff}, 8'h01);
		wr(8'hC4, 8'h05);
		for (n = 0; n < 2; n++)
		begin
			@(posedge clock);
			#1 slotTick = 1'b1;
			@(posedge clock);
			#1 slotTick = 1'b0;
		end
		rd(8'hC4);
		chk("backoff", v, 8'h03);
		wr(8'h94, 8'h02);
		for (n = 0; n < 100 && txBitTick_ff !== 1'b1; n++)
			idle(1);
		idle(1);
		for (n = 1; n < 100 && txBitTick_ff !== 1'b1; n++)
			idle(1);
		chk("bit period", 8'(n), 8'h18);
		wr(8'h84, 8'h80);
		txClkExtIn = 1'b1;
		idle(1);
		chk("ext tick", {7'h00, txBitTick_ff}, 8'h01);
		idle(1);
		chk("ext tick once", {7'h00, txBitTick_ff}, 8'h00);
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		#1000000;
		bad_count++;
		report_and_stop();
	end
	initial
	begin
		{sfrWrite, sfrRead, txActive, portLatchBit, slotTick, txClkExtIn} = 6'h00;
		{sfrAddr, sfrWrData} = 16'h0000;
		rxDataReady = 1'b1;
		reset_n = 1'b0;
		repeat (6) @(posedge clock);
		#1 reset_n = 1'b1;
		t_regs();
		t_mode();
		t_good();
		t_err();
		t_abort();
		t_ovf();
		t_misc();
		report_and_stop();
	end
endmodule // packet_serial_rx_error_config_tb
bind psrx_channel psrx_channel_assertions #(.DATA_W(DATA_W)) u_chk (.clock, .reset_n, .sfrAddr, .sfrWrite, .sfrWrData,
	.rxBitValid, .rxFrameEnd, .rxLineIdle, .rxCollision, .rxData_ff, .rxDataValid_ff, .rxDataReady, .txActive,
	.portLatchBit, .txBitTick_ff, .lineDriverEnable_n_ff, .rxErrorIrq_ff, .preambleBits_ff, .preambleInvalid_ff,
	.channelMode_ff);
`default_nettype wire

/* File: psrx_channel.v */
// Functional notes
// [R1] Four receive error flags live in rx_status_reg, hardware set, software read only.
// [R2] Setting rx_enable_bit clears all four flags; nothing else clears them.
// [R3] Any error flag raises rx_error_irq and clears rx_enable_bit.
// [R4] Any error flag set blocks rx_done_flag for that frame.
// [R5] CRC failure when checker does not end at the expected residue.
// [R6] Alignment failure when frame bit count is not a multiple of 8.
// [R7] SDLC: crc_fail_flag and misalign_flag set independently at frame end.
// [R8] CSMA/CD: CRC only sets crc flag; CRC plus alignment sets only misalign.
// [R9] Abort flag when frame cut off after data entered FIFO.
// [R10] Overflow flag when an assembled byte meets a full FIFO.
// [R11] Up to 7 bits after end flag raise no error.
// [R12] Accept frame on address match; 8-bit any register, 16-bit pairs.
// [R13] Mask bits of 1 exclude address bits from matches 0 and 1.
// [R14] Bit rate is oscillator divided by (divider plus one) times 8.
// [R15] Eight-bit backoff countdown decrements once per slot time.
// [R16] Line driver enable active low while transmitting, gated by port latch.
// [R17] protocol_select 1 means SDLC/NRZI, 0 means CSMA/CD/Manchester.
// [R18] Mode bits: ext clock 7, test 6:5, width 4, crc 3, preamble 2:1, protocol 0.
// [R19] Preamble 0/8/32/64 bits; zero length invalid in CSMA/CD.
// [R20] crc_kind 1 selects 32-bit check, 0 the 16-bit CCITT check.
// [R21] Test modes: normal, raw transmit, raw receive, alternate backoff.
// [R22] ext_tx_clock_sel picks external one-times clock, else baud generator.
// [R23] rx_done_flag only at end of accepted frame with no error flags.
`timescale 1ns/100ps
`default_nettype none
`include "psrx_defines.vh"

module psrx_channel
#(
	parameter DATA_W = 8,
	parameter BUF_DEPTH = 2
)
(
	// Clock and reset
	input wire clock,
	input wire reset_n,
	// Special function register port
	input wire [7:0] sfrAddr,
	input wire sfrWrite,
	input wire sfrRead,
	input wire [7:0] sfrWrData,
	output reg [7:0] sfrRdData_ff,
	// Decoded receive line events
	input wire rxBitValid,
	input wire rxBitValue,
	input wire rxFrameStart,
	input wire rxFrameEnd,
	input wire rxLineIdle,
	input wire rxCollision,
	// Receive byte stream
	output reg [DATA_W-1:0] rxData_ff,
	output reg rxDataValid_ff,
	input wire rxDataReady,
	// Transmit side support
	input wire txActive,
	input wire txClkExtIn,
	input wire portLatchBit,
	input wire slotTick,
	output reg txBitTick_ff,
	output reg lineDriverEnable_n_ff,
	// Status and mode outputs
	output reg rxErrorIrq_ff,
	output reg [6:0] preambleBits_ff,
	output reg preambleInvalid_ff,
	output reg [7:0] channelMode_ff
);

	function [31:0] crcStep;
		input [31:0] crc;
		input bitIn;
		input wide;
		reg fb;
		begin
			if (wide)
			begin
				fb = crc[31] ^ bitIn;
				crcStep = {crc[30:0], 1'b0} ^ (fb ? `PSRX_POLY32 : 32'h00000000);
			end
			else
			begin
				fb = crc[15] ^ bitIn;
				crcStep = {16'h0000, crc[14:0], 1'b0} ^ {16'h0000, (fb ? `PSRX_POLY16 : 16'h0000)};
			end
		end
	endfunction

	function maskedMatch;
		input [15:0] rcv;
		input [15:0] refVal;
		input [15:0] msk;
		begin
			maskedMatch = (((rcv ^ refVal) & ~msk) == 16'h0000);
		end
	endfunction

	reg [7:0] bitRateDiv_ff;
	reg [7:0] addrMatch0_ff;
	reg [7:0] addrMatch1_ff;
	reg [7:0] addrMatch2_ff;
	reg [7:0] addrMatch3_ff;
	reg [7:0] addrMask0_ff;
	reg [7:0] addrMask1_ff;
	reg [7:0] backoff_ff;
	reg rxEnable_ff;
	reg rxDone_ff;
	reg [3:0] rxFlags_ff;
	reg inFrame_ff;
	reg accepted_ff;
	reg dataPushed_ff;
	reg [15:0] bitCnt_ff;
	reg [7:0] shift_ff;
	reg [7:0] addrLow_ff;
	reg byteIdx_ff;
	reg [31:0] crc_ff;
	reg [DATA_W-1:0] bufSecond_ff;
	reg [1:0] bufCnt_ff;
	reg [10:0] baudCnt_ff;
	reg txClkPrev_ff;

	wire modeSdlc = channelMode_ff[`PSRX_MODE_PROTOCOL];
	wire modeCrc32 = channelMode_ff[`PSRX_MODE_CRC_KIND];
	wire modeAddr16 = channelMode_ff[`PSRX_MODE_ADDR_WIDTH];
	wire modeExtClk = channelMode_ff[`PSRX_MODE_EXT_TX_CLK];

	// Software register writes
	wire wrMode = sfrWrite && (sfrAddr == `PSRX_ADDR_CHANNEL_MODE);
	wire wrStatus = sfrWrite && (sfrAddr == `PSRX_ADDR_RX_STATUS);
	wire wrBackoff = sfrWrite && (sfrAddr == `PSRX_ADDR_BACKOFF_COUNTDOWN);
	wire swEnable = wrStatus && sfrWrData[`PSRX_STAT_RX_ENABLE];

	// Bit assembly: first bit on the line lands in bit 0
	wire [7:0] nextByte = {rxBitValue, shift_ff[7:1]};
	wire frameBit = inFrame_ff && rxBitValid && !rxFrameEnd;
	wire byteDone = frameBit && (bitCnt_ff[2:0] == 3'h7);

	// Address recognition; all-ones address is always taken
	wire match8 = (nextByte == 8'hFF) //[R12]
		|| maskedMatch({8'h00, nextByte}, {8'h00, addrMatch0_ff}, {8'h00, addrMask0_ff}) //[R13]
		|| maskedMatch({8'h00, nextByte}, {8'h00, addrMatch1_ff}, {8'h00, addrMask1_ff}) //[R13]
		|| (nextByte == addrMatch2_ff)
		|| (nextByte == addrMatch3_ff);
	wire match16 = ({nextByte, addrLow_ff} == 16'hFFFF) //[R12]
		|| maskedMatch({nextByte, addrLow_ff}, {addrMatch1_ff, addrMatch0_ff}, {addrMask1_ff, addrMask0_ff}) //[R13]
		|| ({nextByte, addrLow_ff} == {addrMatch3_ff, addrMatch2_ff});

	// Buffer handshake
	wire popBuf = rxDataValid_ff && rxDataReady;
	wire bufFull = (bufCnt_ff == 2'd2);
	wire addrByte = byteDone && !accepted_ff;
	wire pushOne = byteDone && (accepted_ff || (!modeAddr16 && match8)) && !bufFull;
	wire pushTwo = addrByte && modeAddr16 && byteIdx_ff && match16 && (bufCnt_ff == 2'd0);
	wire overflowEv = byteDone && (accepted_ff ? bufFull //[R10]
		: (modeAddr16 ? (byteIdx_ff && match16 && (bufCnt_ff != 2'd0)) : (match8 && bufFull)));

	// Frame end checks
	wire endAccepted = inFrame_ff && rxFrameEnd && accepted_ff;
	wire crcBad = modeCrc32 ? (crc_ff != `PSRX_RESIDUE32) //[R5][R20]
		: (crc_ff[15:0] != `PSRX_RESIDUE16);
	wire alignBad = (bitCnt_ff[2:0] != 3'h0); //[R6]
	wire setCrc = endAccepted && crcBad && (modeSdlc || !alignBad); //[R7][R8]
	wire setAlign = endAccepted && alignBad && (modeSdlc || crcBad); //[R7][R8]
	wire cutOff = modeSdlc ? rxLineIdle : rxCollision; //[R17]
	wire setAbort = inFrame_ff && !rxFrameEnd && cutOff && dataPushed_ff; //[R9]

	reg [3:0] nxt_rxFlags;
	reg nxt_rxEnable;
	reg nxt_rxDone;

	// Flags: the hardware set wins over the enable clear
	always @*
	begin
		nxt_rxFlags = swEnable ? 4'h0 : rxFlags_ff; //[R2]
		nxt_rxFlags = nxt_rxFlags | {overflowEv, setAbort, setAlign, setCrc}; //[R1]
		nxt_rxEnable = swEnable ? 1'b1 : ((|rxFlags_ff) ? 1'b0 : rxEnable_ff); //[R3]
		nxt_rxDone = swEnable ? 1'b0 : rxDone_ff;
		if (endAccepted && !setCrc && !setAlign && (nxt_rxFlags == 4'h0))
		begin
			nxt_rxDone = 1'b1; //[R4][R23]
		end
	end

	always @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rxFlags_ff <= 4'h0;
			rxEnable_ff <= 1'b0;
			rxDone_ff <= 1'b0;
			rxErrorIrq_ff <= 1'b0;
		end
		else
		begin
			rxFlags_ff <= nxt_rxFlags;
			rxEnable_ff <= nxt_rxEnable;
			rxDone_ff <= nxt_rxDone;
			rxErrorIrq_ff <= |nxt_rxFlags; //[R3]
		end
	end

	// Frame tracker; bits after the end flag find inFrame low and are dropped
	always @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			inFrame_ff <= 1'b0;
			accepted_ff <= 1'b0;
			dataPushed_ff <= 1'b0;
			bitCnt_ff <= 16'h0000;
			shift_ff <= 8'h00;
			addrLow_ff <= 8'h00;
			byteIdx_ff <= 1'b0;
			crc_ff <= `PSRX_CRC_SEED;
		end
		else if (rxFrameStart && rxEnable_ff && !(|nxt_rxFlags))
		begin
			inFrame_ff <= 1'b1;
			accepted_ff <= 1'b0;
			dataPushed_ff <= 1'b0;
			bitCnt_ff <= 16'h0000;
			shift_ff <= 8'h00;
			byteIdx_ff <= 1'b0;
			crc_ff <= `PSRX_CRC_SEED;
		end
		else if (inFrame_ff && (rxFrameEnd || setAbort || (|nxt_rxFlags) || !rxEnable_ff))
		begin
			inFrame_ff <= 1'b0; //[R11]
		end
		else if (frameBit)
		begin
			bitCnt_ff <= bitCnt_ff + 16'h0001;
			shift_ff <= nextByte;
			crc_ff <= crcStep(crc_ff, rxBitValue, modeCrc32);
			if (byteDone)
			begin
				byteIdx_ff <= 1'b1;
				if (pushOne || pushTwo)
				begin
					dataPushed_ff <= 1'b1;
				end
				if (!accepted_ff)
				begin
					if (!modeAddr16)
					begin
						accepted_ff <= match8; //[R12]
						inFrame_ff <= match8;
					end
					else if (!byteIdx_ff)
					begin
						addrLow_ff <= nextByte;
					end
					else
					begin
						accepted_ff <= match16; //[R12]
						inFrame_ff <= match16;
					end
				end
			end
		end
	end

	// Two-entry buffer; the head entry drives the stream output directly
	always @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rxData_ff <= {DATA_W{1'b0}};
			bufSecond_ff <= {DATA_W{1'b0}};
			bufCnt_ff <= 2'd0;
			rxDataValid_ff <= 1'b0;
		end
		else if (pushTwo)
		begin
			rxData_ff <= addrLow_ff[DATA_W-1:0];
			bufSecond_ff <= nextByte[DATA_W-1:0];
			bufCnt_ff <= 2'd2;
			rxDataValid_ff <= 1'b1;
		end
		else if (pushOne && popBuf)
		begin
			if (bufCnt_ff == 2'd2)
			begin
				rxData_ff <= bufSecond_ff;
				bufSecond_ff <= nextByte[DATA_W-1:0];
			end
			else
			begin
				rxData_ff <= nextByte[DATA_W-1:0];
			end
		end
		else if (pushOne)
		begin
			if (bufCnt_ff == 2'd0)
			begin
				rxData_ff <= nextByte[DATA_W-1:0];
			end
			else
			begin
				bufSecond_ff <= nextByte[DATA_W-1:0];
			end
			bufCnt_ff <= bufCnt_ff + 2'd1;
			rxDataValid_ff <= 1'b1;
		end
		else if (popBuf)
		begin
			rxData_ff <= bufSecond_ff;
			bufCnt_ff <= bufCnt_ff - 2'd1;
			rxDataValid_ff <= (bufCnt_ff == 2'd2);
		end
	end

	// Configuration registers
	always @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			channelMode_ff <= `PSRX_RST_BYTE;
			bitRateDiv_ff <= `PSRX_RST_BYTE;
			addrMatch0_ff <= `PSRX_RST_BYTE;
			addrMatch1_ff <= `PSRX_RST_BYTE;
			addrMatch2_ff <= `PSRX_RST_BYTE;
			addrMatch3_ff <= `PSRX_RST_BYTE;
			addrMask0_ff <= `PSRX_RST_BYTE;
			addrMask1_ff <= `PSRX_RST_BYTE;
		end
		else if (sfrWrite)
		begin
			if (wrMode)
			begin
				channelMode_ff <= sfrWrData; //[R18]
			end
			else if (sfrAddr == `PSRX_ADDR_BIT_RATE_DIVIDER)
			begin
				bitRateDiv_ff <= sfrWrData;
			end
			else if (sfrAddr == `PSRX_ADDR_ADDRESS_MATCH_0)
			begin
				addrMatch0_ff <= sfrWrData;
			end
			else if (sfrAddr == `PSRX_ADDR_ADDRESS_MATCH_1)
			begin
				addrMatch1_ff <= sfrWrData;
			end
			else if (sfrAddr == `PSRX_ADDR_ADDRESS_MATCH_2)
			begin
				addrMatch2_ff <= sfrWrData;
			end
			else if (sfrAddr == `PSRX_ADDR_ADDRESS_MATCH_3)
			begin
				addrMatch3_ff <= sfrWrData;
			end
			else if (sfrAddr == `PSRX_ADDR_ADDRESS_MASK_0)
			begin
				addrMask0_ff <= sfrWrData;
			end
			else if (sfrAddr == `PSRX_ADDR_ADDRESS_MASK_1)
			begin
				addrMask1_ff <= sfrWrData;
			end
		end
	end

	// Read mux, registered so the output comes from a flop
	reg [7:0] nxt_rdData;
	always @*
	begin
		nxt_rdData = 8'h00;
		if (sfrAddr == `PSRX_ADDR_CHANNEL_MODE)
			nxt_rdData = channelMode_ff;
		else if (sfrAddr == `PSRX_ADDR_BIT_RATE_DIVIDER)
			nxt_rdData = bitRateDiv_ff;
		else if (sfrAddr == `PSRX_ADDR_ADDRESS_MATCH_0)
			nxt_rdData = addrMatch0_ff;
		else if (sfrAddr == `PSRX_ADDR_ADDRESS_MATCH_1)
			nxt_rdData = addrMatch1_ff;
		else if (sfrAddr == `PSRX_ADDR_ADDRESS_MATCH_2)
			nxt_rdData = addrMatch2_ff;
		else if (sfrAddr == `PSRX_ADDR_BACKOFF_COUNTDOWN)
			nxt_rdData = backoff_ff;
		else if (sfrAddr == `PSRX_ADDR_ADDRESS_MATCH_3)
			nxt_rdData = addrMatch3_ff;
		else if (sfrAddr == `PSRX_ADDR_ADDRESS_MASK_0)
			nxt_rdData = addrMask0_ff;
		else if (sfrAddr == `PSRX_ADDR_ADDRESS_MASK_1)
			nxt_rdData = addrMask1_ff;
		else if (sfrAddr == `PSRX_ADDR_RX_STATUS)
			nxt_rdData = {rxFlags_ff, 2'b00, rxDone_ff, rxEnable_ff}; //[R1]
	end

	always @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			sfrRdData_ff <= 8'h00;
		else if (sfrRead)
			sfrRdData_ff <= nxt_rdData;
	end

	// Backoff countdown; a software write wins over the slot decrement
	always @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			backoff_ff <= `PSRX_RST_BYTE;
		else if (wrBackoff)
			backoff_ff <= sfrWrData;
		else if (slotTick && (backoff_ff != 8'h00))
			backoff_ff <= backoff_ff - 8'h01; //[R15]
	end

	// Bit clock: (divider + 1) * 8 oscillator cycles per bit
	wire [10:0] baudTerminal = ({3'b000, bitRateDiv_ff} + 11'h001) * `PSRX_BAUD_PRESCALE - 11'h001;
	wire baudTick = (baudCnt_ff >= baudTerminal);
	wire extEdge = txClkExtIn && !txClkPrev_ff;

	always @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			baudCnt_ff <= 11'h000;
			txClkPrev_ff <= 1'b0;
			txBitTick_ff <= 1'b0;
			lineDriverEnable_n_ff <= 1'b1;
			preambleBits_ff <= `PSRX_PREAMBLE_00;
			preambleInvalid_ff <= 1'b0;
		end
		else
		begin
			baudCnt_ff <= baudTick ? 11'h000 : baudCnt_ff + 11'h001; //[R14]
			txClkPrev_ff <= txClkExtIn;
			txBitTick_ff <= modeExtClk ? extEdge : baudTick; //[R22]
			lineDriverEnable_n_ff <= !(txActive && portLatchBit); //[R16]
			case (channelMode_ff[`PSRX_MODE_PRE_HI:`PSRX_MODE_PRE_LO]) //[R19]
				2'b00: preambleBits_ff <= `PSRX_PREAMBLE_00;
				2'b01: preambleBits_ff <= `PSRX_PREAMBLE_01;
				2'b10: preambleBits_ff <= `PSRX_PREAMBLE_10;
				default: preambleBits_ff <= `PSRX_PREAMBLE_11;
			endcase
			preambleInvalid_ff <= !modeSdlc && (channelMode_ff[`PSRX_MODE_PRE_HI:`PSRX_MODE_PRE_LO] == 2'b00);
		end
	end

	// Test mode bits 6:5 are carried out on channelMode_ff for the transmitter [R21]

endmodule // psrx_channel
`default_nettype wire

/* File: psrx_channel_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module psrx_channel_assertions
#(
	parameter DATA_W = 8
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Register port
	input wire logic [7:0] sfrAddr,
	input wire logic sfrWrite,
	input wire logic [7:0] sfrWrData,
	// Receive side
	input wire logic rxBitValid,
	input wire logic rxFrameEnd,
	input wire logic rxLineIdle,
	input wire logic rxCollision,
	input wire logic [DATA_W-1:0] rxData_ff,
	input wire logic rxDataValid_ff,
	input wire logic rxDataReady,
	// Transmit support and status
	input wire logic txActive,
	input wire logic portLatchBit,
	input wire logic txBitTick_ff,
	input wire logic lineDriverEnable_n_ff,
	input wire logic rxErrorIrq_ff,
	input wire logic [6:0] preambleBits_ff,
	input wire logic preambleInvalid_ff,
	input wire logic [7:0] channelMode_ff
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);
	wire stWr = sfrWrite && sfrAddr == 8'hE8 && sfrWrData[0];
	wire modeWr = sfrWrite && sfrAddr == 8'h84;
	wire rxEv = rxBitValid || rxFrameEnd || rxLineIdle || rxCollision;
	reg [1:0] modeAge_ff;
	reg [7:0] div_ff;
	reg [11:0] gap_ff;
	reg seen_ff;
	// Period judged only after a full period at a settled divider
	always @(posedge clock or negedge reset_n)
		if (!reset_n)
		begin
			modeAge_ff <= 2'h0;
			div_ff <= 8'h00;
			gap_ff <= 12'h000;
			seen_ff <= 1'b0;
		end
		else
		begin
			modeAge_ff <= modeWr ? 2'h0 : modeAge_ff + {1'b0, modeAge_ff != 2'h3};
			if (sfrWrite && sfrAddr == 8'h94)
				div_ff <= sfrWrData;
			seen_ff <= (modeWr || (sfrWrite && sfrAddr == 8'h94)) ? 1'b0 : seen_ff | txBitTick_ff;
			gap_ff <= txBitTick_ff ? 12'h001 : gap_ff + 12'h001;
		end
	a_irq_cause: assert property ($rose(rxErrorIrq_ff) |-> $past(rxEv) || $past(rxEv, 2))
		else $error("error irq rose with no receive event");
	a_irq_hold: assert property (rxErrorIrq_ff && !stWr |=> rxErrorIrq_ff)
		else $error("error irq dropped without enable write");
	a_irq_clear: assert property (rxErrorIrq_ff && stWr && !rxEv |=> !rxErrorIrq_ff)
		else $error("enable write left error irq set");
	a_pre_len: assert property (modeAge_ff == 2'h3 |-> preambleBits_ff == (channelMode_ff[2:1] == 2'h0 ? 7'h00 :
		channelMode_ff[2:1] == 2'h1 ? 7'h08 : channelMode_ff[2:1] == 2'h2 ? 7'h20 : 7'h40))
		else $error("preamble length wrong");
	a_pre_bad: assert property (modeAge_ff == 2'h3 |-> preambleInvalid_ff == (channelMode_ff[2:0] == 3'h0))
		else $error("preamble invalid flag wrong");
	a_drv_en: assert property ($past(reset_n) |-> lineDriverEnable_n_ff == !($past(txActive) && $past(portLatchBit)))
		else $error("line driver enable wrong");
	a_mode_wr: assert property (modeWr |=> channelMode_ff == $past(sfrWrData))
		else $error("mode write lost");
	a_bit_rate: assert property (txBitTick_ff && seen_ff && !channelMode_ff[7] |-> gap_ff == ({4'h0, div_ff} + 12'h001) * 12'h008)
		else $error("bit period wrong");
	a_buf_hold: assert property (rxDataValid_ff && !rxDataReady |=> rxDataValid_ff && $stable(rxData_ff))
		else $error("stalled head byte lost");
	c_err: cover property ($rose(rxErrorIrq_ff));
	c_full: cover property (rxDataValid_ff && !rxDataReady);
	c_tick: cover property (txBitTick_ff && seen_ff);
endmodule // psrx_channel_assertions
`default_nettype wire

/* File: psrx_defines.vh */
`ifndef PSRX_DEFINES_VH
`define PSRX_DEFINES_VH

// Register offsets in special function register space
`define PSRX_ADDR_CHANNEL_MODE 8'h84
`define PSRX_ADDR_BIT_RATE_DIVIDER 8'h94
`define PSRX_ADDR_ADDRESS_MATCH_0 8'h95
`define PSRX_ADDR_ADDRESS_MATCH_1 8'hA5
`define PSRX_ADDR_ADDRESS_MATCH_2 8'hB5
`define PSRX_ADDR_BACKOFF_COUNTDOWN 8'hC4
`define PSRX_ADDR_ADDRESS_MATCH_3 8'hC5
`define PSRX_ADDR_ADDRESS_MASK_0 8'hD5
`define PSRX_ADDR_ADDRESS_MASK_1 8'hE5
`define PSRX_ADDR_RX_STATUS 8'hE8

// Reset values
`define PSRX_RST_BYTE 8'h00

// channel_mode fields
`define PSRX_MODE_PROTOCOL 0
`define PSRX_MODE_PRE_LO 1
`define PSRX_MODE_PRE_HI 2
`define PSRX_MODE_CRC_KIND 3
`define PSRX_MODE_ADDR_WIDTH 4
`define PSRX_MODE_TEST_LO 5
`define PSRX_MODE_TEST_HI 6
`define PSRX_MODE_EXT_TX_CLK 7

// rx_status_reg fields
`define PSRX_STAT_RX_ENABLE 0
`define PSRX_STAT_RX_DONE 1
`define PSRX_STAT_CRC_FAIL 4
`define PSRX_STAT_MISALIGN 5
`define PSRX_STAT_ABORT 6
`define PSRX_STAT_OVERFLOW 7

// Preamble lengths in bits
`define PSRX_PREAMBLE_00 7'h00
`define PSRX_PREAMBLE_01 7'h08
`define PSRX_PREAMBLE_10 7'h20
`define PSRX_PREAMBLE_11 7'h40

// Check field polynomials, seed and good residues
`define PSRX_POLY16 16'h1021
`define PSRX_POLY32 32'h04C11DB7
`define PSRX_CRC_SEED 32'hFFFFFFFF
`define PSRX_RESIDUE16 16'h1D0F
`define PSRX_RESIDUE32 32'hC704DD7B

// Bit clock prescale per divider step
`define PSRX_BAUD_PRESCALE 11'h008

`endif

/* File: psrx_remote_station.sv */
`timescale 1ns/100ps
`default_nettype none
`include "psrx_defines.vh"
module psrx_remote_station
(
	// Clock
	input wire logic clock,
	// Decoded line events
	output logic rxBitValid,
	output logic rxBitValue,
	output logic rxFrameStart,
	output logic rxFrameEnd,
	output logic rxLineIdle,
	output logic rxCollision
);
	logic [7:0] pay [$];
	initial
	begin
		rxBitValid = 1'b0;
		rxBitValue = 1'b1;
		rxFrameStart = 1'b0;
		rxFrameEnd = 1'b0;
		rxLineIdle = 1'b0;
		rxCollision = 1'b0;
	end
	// Data line shows the inverse once released, never a stale bit
	task automatic send_bit(input logic b);
		@(posedge clock);
		#1 rxBitValid = 1'b1;
		rxBitValue = b;
		@(posedge clock);
		#1 rxBitValid = 1'b0;
		rxBitValue = ~b;
	endtask
	task automatic send(input logic [7:0] pre, input logic bad, input logic [7:0] post, input logic cut);
		logic [15:0] c;
		logic b;
		c = 16'hFFFF;
		@(posedge clock);
		#1 rxFrameStart = 1'b1;
		@(posedge clock);
		#1 rxFrameStart = 1'b0;
		for (int i = 0; i < pay.size() * 8 + pre; i++)
		begin
			b = i < pay.size() * 8 ? pay[i / 8][i % 8] : 1'b0;
			send_bit(b);
			b = b ^ c[15];
			c = {c[14:0], 1'b0} ^ (b ? `PSRX_POLY16 : 16'h0000);
		end
		@(posedge clock);
		#1 rxLineIdle = cut;
		@(posedge clock);
		#1 rxLineIdle = 1'b0;
		if (!cut)
		begin
			c = ~c ^ {15'h0000, bad};
			for (int k = 15; k >= 0; k--)
				send_bit(c[k]);
			@(posedge clock);
			#1 rxFrameEnd = 1'b1;
			@(posedge clock);
			#1 rxFrameEnd = 1'b0;
			for (int k = 0; k < post; k++)
				send_bit(1'b1);
		end
	endtask
endmodule // psrx_remote_station
`default_nettype wire
